// File: core/vemr_map.vh
// Register map, field positions, reset values and level figures of the encoder mode registers
`ifndef VEMR_MAP_VH
`define VEMR_MAP_VH

// ==========================================================
// Subaddresses
`define VEMR_ADDR_DAC      8'h01
`define VEMR_ADDR_OUT      8'h02
`define VEMR_ADDR_VBI      8'h03
`define VEMR_ADDR_SYNC     8'h04
`define VEMR_ADDR_LEVEL    8'h05

// ==========================================================
// Reset values
`define VEMR_RST_DAC       8'h00
`define VEMR_RST_OUT       8'h00
`define VEMR_RST_VBI       8'h00
`define VEMR_RST_SYNC      8'h00
`define VEMR_RST_LEVEL     8'h00

// ==========================================================
// Field positions
`define VEMR_B_LOWPWR      6
`define VEMR_B_YUV         0
`define VEMR_B_LARGE       1
`define VEMR_B_SCART       2
`define VEMR_B_PED         3
`define VEMR_B_SQPIX       4
`define VEMR_B_STDSRC      5
`define VEMR_B_PIXVALID    6
`define VEMR_B_SLEEP       7
`define VEMR_B_VBIPASS     2
`define VEMR_B_TTXEN       3
`define VEMR_B_TTXMODE     4
`define VEMR_B_VS3H        0
`define VEMR_B_GLEN        1
`define VEMR_B_GLMODE      2
`define VEMR_B_LINEDUR     3
`define VEMR_B_CHROMA      4
`define VEMR_B_BURST       5
`define VEMR_B_CBAR        6
`define VEMR_B_YLEVEL      0
`define VEMR_B_UVLO        1

// ==========================================================
// Standards and DAC source codes
`define VEMR_STD_NTSC      2'b00
`define VEMR_SRC_CVBS      3'h0
`define VEMR_SRC_LUMA      3'h1
`define VEMR_SRC_CHROMA    3'h2
`define VEMR_SRC_GY        3'h3
`define VEMR_SRC_BU        3'h4
`define VEMR_SRC_RV        3'h5

// ==========================================================
// Line, pixel and level figures
`define VEMR_VS_HALF_NTSC  3'h6
`define VEMR_VS_HALF_PAL   3'h5
`define VEMR_PIX_FULL      10'h2d0
`define VEMR_PIX_NTSC      10'h2c6
`define VEMR_PIX_PAL       10'h2be
`define VEMR_UV_700        11'h2bc
`define VEMR_UV_1000       11'h3e8
`define VEMR_UV_934        11'h3a6

`endif

// File: core/vemr_dac_router.v
// DAC output source selection for the six DACs
`timescale 1ns/1ps
`default_nettype none
`include "vemr_map.vh"

module vemr_dac_router
(
    input  wire        scartSel,
    input  wire        largeSel,
    output reg  [17:0] dacSrc
);

    // ==========================================================
    // Routing table, DAC A in the low bits
    always @*
    begin
        if (largeSel)
        begin
            dacSrc = {`VEMR_SRC_RV, `VEMR_SRC_BU, `VEMR_SRC_GY,
                      `VEMR_SRC_CHROMA, `VEMR_SRC_LUMA, `VEMR_SRC_CVBS};
        end
        else if (scartSel)
        begin
            dacSrc = {`VEMR_SRC_CHROMA, `VEMR_SRC_LUMA, `VEMR_SRC_GY,
                      `VEMR_SRC_RV, `VEMR_SRC_BU, `VEMR_SRC_CVBS};
        end
        else
        begin
            dacSrc = {`VEMR_SRC_CHROMA, `VEMR_SRC_LUMA, `VEMR_SRC_CVBS,
                      `VEMR_SRC_RV, `VEMR_SRC_BU, `VEMR_SRC_GY};
        end
    end

endmodule
`default_nettype wire

// File: core/vemr_sleep_ctrl.v
// Sleep source selection between the software bit and the strap pins
`timescale 1ns/1ps
`default_nettype none

module vemr_sleep_ctrl
(
    input  wire clock,
    input  wire resetn,
    input  wire handover,
    input  wire sleepBit,
    input  wire subcarrierResetPin,
    input  wire standardSelectPin,
    output reg  sleepActive
);

    // ==========================================================
    // Sleep state
    wire pinSleep;
    wire sleepD;

    assign pinSleep = subcarrierResetPin & standardSelectPin;
    assign sleepD = handover ? sleepBit : pinSleep;

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            sleepActive <= 1'b0;
        else
            sleepActive <= sleepD;
    end

endmodule
`default_nettype wire

// File: core/vemr_mode_regs.v
// Mode registers one to five of the video encoder and their decoded controls
`timescale 1ns/1ps
`default_nettype none
`include "vemr_map.vh"

module vemr_mode_regs
#(
    parameter [1:0] REVISION = 2'h1 // Arbitrary value
)
(
    input  wire        clock,
    input  wire        resetn,
    // Register access by subaddress
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output wire        regAddrHit,
    output reg  [7:0]  regRdData,
    output reg         regRdValid,
    // State held in neighbouring registers
    input  wire [1:0]  standardFilterStd,
    input  wire        powerUpSleepHandover,
    input  wire        timingMasterSel,
    input  wire        blankInputEnable,
    // Pins
    input  wire        standardSelectPin,
    input  wire        subcarrierResetPin,
    input  wire        teletextDataIn,
    input  wire        teletextBitRequest,
    output wire        teletextRequestOut,
    // DAC controls
    output reg  [5:0]  dacPowerDownBits,
    output reg  [5:0]  dacLowPower,
    output reg  [17:0] dacSource,
    output reg         yuvSelect,
    // Video controls
    output reg         isNtsc,
    output reg         pedestalOn,
    output reg         squarePixelOn,
    output reg         pixelBlank,
    output reg         masterTiming,
    output wire        sleepActive,
    output reg         vbiDataPass,
    output reg         teletextInsert,
    output reg         teletextData,
    output reg  [2:0]  vsyncHalfLines,
    output reg         subcarrierPhaseReset,
    output reg         rtcLockEnable,
    output reg  [9:0]  activePixels,
    output reg         chromaOn,
    output reg         burstOn,
    output reg         colorBarOn,
    output reg         syncPinsOe,
    output reg         ySmpteLevel,
    output reg  [10:0] uvLevelMv
);

    // ==========================================================
    // Decoding functions
    function isMapped;
        input [7:0] a;
        begin
            isMapped = (a == `VEMR_ADDR_DAC) || (a == `VEMR_ADDR_OUT) ||
                       (a == `VEMR_ADDR_VBI) || (a == `VEMR_ADDR_SYNC) ||
                       (a == `VEMR_ADDR_LEVEL);
        end
    endfunction

    function stdNtsc;
        input [1:0] std;
        begin
            stdNtsc = (std == `VEMR_STD_NTSC);
        end
    endfunction

    // ==========================================================
    // Register storage
    reg [7:0] dacPowerControl_q;
    reg [7:0] outputSleepControl_q;
    reg [7:0] vbiTeletextCaptionControl_q;
    reg [7:0] syncGenlockColorControl_q;
    reg [7:0] outputLevelClampControl_q;

    wire [7:0] vbiReadView;

    assign regAddrHit = isMapped(regAddr);

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            dacPowerControl_q           <= `VEMR_RST_DAC;
            outputSleepControl_q        <= `VEMR_RST_OUT;
            vbiTeletextCaptionControl_q <= `VEMR_RST_VBI;
            syncGenlockColorControl_q   <= `VEMR_RST_SYNC;
            outputLevelClampControl_q   <= `VEMR_RST_LEVEL;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `VEMR_ADDR_DAC:
                    dacPowerControl_q <= regWrData;
                `VEMR_ADDR_OUT:
                    outputSleepControl_q <= regWrData;
                `VEMR_ADDR_VBI:
                    vbiTeletextCaptionControl_q <= regWrData;
                `VEMR_ADDR_SYNC:
                    syncGenlockColorControl_q <= regWrData;
                `VEMR_ADDR_LEVEL:
                    outputLevelClampControl_q <= regWrData;
                default:
                    dacPowerControl_q <= dacPowerControl_q;
            endcase
        end
    end

    // ==========================================================
    // Read-back
    assign vbiReadView = {vbiTeletextCaptionControl_q[7:2], REVISION};

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead & regAddrHit;
            if (regRead)
            begin
                case (regAddr)
                    `VEMR_ADDR_DAC:
                        regRdData <= dacPowerControl_q;
                    `VEMR_ADDR_OUT:
                        regRdData <= outputSleepControl_q;
                    `VEMR_ADDR_VBI:
                        regRdData <= vbiReadView;
                    `VEMR_ADDR_SYNC:
                        regRdData <= syncGenlockColorControl_q;
                    `VEMR_ADDR_LEVEL:
                        regRdData <= outputLevelClampControl_q;
                    default:
                        regRdData <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Field aliases
    wire       lowPowerBit  = dacPowerControl_q[`VEMR_B_LOWPWR];
    wire       yuvBit       = outputSleepControl_q[`VEMR_B_YUV];
    wire       largeBit     = outputSleepControl_q[`VEMR_B_LARGE];
    wire       scartBit     = outputSleepControl_q[`VEMR_B_SCART];
    wire       pedestalBit  = outputSleepControl_q[`VEMR_B_PED];
    wire       squareBit    = outputSleepControl_q[`VEMR_B_SQPIX];
    wire       stdSrcBit    = outputSleepControl_q[`VEMR_B_STDSRC];
    wire       pixValidBit  = outputSleepControl_q[`VEMR_B_PIXVALID];
    wire       sleepBit     = outputSleepControl_q[`VEMR_B_SLEEP];
    wire       vbiPassBit   = vbiTeletextCaptionControl_q[`VEMR_B_VBIPASS];
    wire       ttxEnBit     = vbiTeletextCaptionControl_q[`VEMR_B_TTXEN];
    wire       ttxModeBit   = vbiTeletextCaptionControl_q[`VEMR_B_TTXMODE];
    wire       vs3hBit      = syncGenlockColorControl_q[`VEMR_B_VS3H];
    wire       glEnBit      = syncGenlockColorControl_q[`VEMR_B_GLEN];
    wire       glModeBit    = syncGenlockColorControl_q[`VEMR_B_GLMODE];
    wire       lineDurBit   = syncGenlockColorControl_q[`VEMR_B_LINEDUR];
    wire       chromaBit    = syncGenlockColorControl_q[`VEMR_B_CHROMA];
    wire       burstBit     = syncGenlockColorControl_q[`VEMR_B_BURST];
    wire       cbarBit      = syncGenlockColorControl_q[`VEMR_B_CBAR];
    wire       yLevelBit    = outputLevelClampControl_q[`VEMR_B_YLEVEL];
    wire [1:0] uvField      = outputLevelClampControl_q[`VEMR_B_UVLO+1:`VEMR_B_UVLO];

    // ==========================================================
    // Standard in force
    wire [1:0] pinStd;
    wire       ntscNow;

    assign pinStd  = standardSelectPin ? 2'b01 : `VEMR_STD_NTSC;
    assign ntscNow = stdSrcBit ? stdNtsc(standardFilterStd) : stdNtsc(pinStd);

    // ==========================================================
    // DAC routing and power
    wire [17:0] routeSrc;
    wire [5:0]  lowPowerD;

    vemr_dac_router u_router
    (
        .scartSel (scartBit),
        .largeSel (largeBit),
        .dacSrc   (routeSrc)
    );

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_lp
            if (g < 3)
            begin : g_large
                assign lowPowerD[g] = lowPowerBit & ~dacPowerControl_q[g];
            end
            else
            begin : g_small
                assign lowPowerD[g] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Sleep
    vemr_sleep_ctrl u_sleep
    (
        .clock              (clock),
        .resetn             (resetn),
        .handover           (powerUpSleepHandover),
        .sleepBit           (sleepBit),
        .subcarrierResetPin (subcarrierResetPin),
        .standardSelectPin  (standardSelectPin),
        .sleepActive        (sleepActive)
    );

    // ==========================================================
    // Teletext request, steady high or per bit
    assign teletextRequestOut = ttxEnBit & (ttxModeBit ? teletextBitRequest : 1'b1);

    // ==========================================================
    // Genlock pin edge
    reg scPin_q;

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            scPin_q <= 1'b0;
        else
            scPin_q <= subcarrierResetPin;
    end

    // ==========================================================
    // Decoded level and pixel figures
    reg [9:0]  pixD;
    reg [10:0] uvD;

    always @*
    begin
        if (!lineDurBit)
            pixD = `VEMR_PIX_FULL;
        else if (ntscNow)
            pixD = `VEMR_PIX_NTSC;
        else
            pixD = `VEMR_PIX_PAL;
        case (uvField)
            2'b01:
                uvD = `VEMR_UV_700;
            2'b10:
                uvD = `VEMR_UV_1000;
            default:
                uvD = ntscNow ? `VEMR_UV_934 : `VEMR_UV_700;
        endcase
    end

    // ==========================================================
    // Registered control outputs
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            dacPowerDownBits     <= 6'h00;
            dacLowPower          <= 6'h00;
            dacSource            <= 18'h00000;
            yuvSelect            <= 1'b0;
            isNtsc               <= 1'b0;
            pedestalOn           <= 1'b0;
            squarePixelOn        <= 1'b0;
            pixelBlank           <= 1'b1;
            masterTiming         <= 1'b1;
            vbiDataPass          <= 1'b0;
            teletextInsert       <= 1'b0;
            teletextData         <= 1'b0;
            vsyncHalfLines       <= 3'h0;
            subcarrierPhaseReset <= 1'b0;
            rtcLockEnable        <= 1'b0;
            activePixels         <= `VEMR_PIX_FULL;
            chromaOn             <= 1'b0;
            burstOn              <= 1'b0;
            colorBarOn           <= 1'b0;
            syncPinsOe           <= 1'b1;
            ySmpteLevel          <= 1'b0;
            uvLevelMv            <= `VEMR_UV_700;
        end
        else
        begin
            dacPowerDownBits     <= dacPowerControl_q[5:0];
            dacLowPower          <= lowPowerD;
            dacSource            <= routeSrc;
            yuvSelect            <= yuvBit;
            isNtsc               <= ntscNow;
            pedestalOn           <= pedestalBit & ntscNow;
            squarePixelOn        <= squareBit;
            pixelBlank           <= ~pixValidBit;
            masterTiming         <= ~pixValidBit | cbarBit | timingMasterSel;
            vbiDataPass          <= vbiPassBit & ~blankInputEnable;
            teletextInsert       <= ttxEnBit;
            teletextData         <= ttxEnBit & teletextDataIn;
            vsyncHalfLines       <= vs3hBit ? (ntscNow ? `VEMR_VS_HALF_NTSC : `VEMR_VS_HALF_PAL) : 3'h0;
            subcarrierPhaseReset <= glEnBit & ~glModeBit & subcarrierResetPin & ~scPin_q;
            rtcLockEnable        <= glEnBit & glModeBit;
            activePixels         <= pixD;
            chromaOn             <= chromaBit;
            burstOn              <= burstBit;
            colorBarOn           <= cbarBit;
            syncPinsOe           <= ~cbarBit;
            ySmpteLevel          <= ntscNow ? yLevelBit : ~yLevelBit;
            uvLevelMv            <= uvD;
        end
    end

endmodule
`default_nettype wire

// File: dv/vemr_host.sv
// Host model issuing single register writes and reads
`timescale 1ns/1ps
`default_nettype none
module vemr_host
(
    input  wire logic       clock,
    output var  logic [7:0] regAddr,
    output var  logic [7:0] regWrData,
    output var  logic       regWrite,
    output var  logic       regRead
);
    initial
    begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWrite  = 1'b0;
        regRead   = 1'b0;
    end

    // ==========
    // Bus cycles, strobe held for the one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d & ((a == 8'h01) ? 8'h7f : (a == 8'h02) ? 8'hef : 8'hff);
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
        regWrData <= ~d;
        regAddr   <= ~a;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule
`default_nettype wire

// File: dv/vemr_mode_regs_chk.sv
// Port-level assertions of the mode register block
`timescale 1ns/1ps
`default_nettype none
module vemr_mode_regs_chk
#(
    parameter logic [1:0] REVISION = 2'h1
)
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic [7:0] regAddr,
    input wire logic       regRead,
    input wire logic       regAddrHit,
    input wire logic       regRdValid,
    input wire logic [7:0] regRdData,
    input wire logic [5:0] dacPowerDownBits,
    input wire logic [5:0] dacLowPower,
    input wire logic       pixelBlank,
    input wire logic       masterTiming,
    input wire logic       colorBarOn,
    input wire logic       syncPinsOe,
    input wire logic       blankInputEnable,
    input wire logic       vbiDataPass,
    input wire logic       powerUpSleepHandover,
    input wire logic       subcarrierResetPin,
    input wire logic       standardSelectPin,
    input wire logic       sleepActive,
    input wire logic       subcarrierPhaseReset,
    input wire logic       rtcLockEnable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // ==========
    // Registers and controls
    revision_code_a: assert property (regRead && regAddr == 8'h03 |=> regRdData[1:0] == REVISION)
        else $error("revision code wrong");
    addr_hit_a: assert property (regAddrHit == (regAddr >= 8'h01 && regAddr <= 8'h05))
        else $error("address hit wrong");
    read_valid_a: assert property (regRdValid == ($past(regRead) && $past(regAddr) >= 8'h01 && $past(regAddr) <= 8'h05))
        else $error("read valid wrong");
    low_power_a: assert property (dacLowPower[5:3] == 3'h0 && (dacLowPower[2:0] & dacPowerDownBits[2:0]) == 3'h0)
        else $error("low power on wrong DAC");
    pixel_blank_a: assert property (pixelBlank |-> masterTiming)
        else $error("blanking without master timing");
    color_bar_a: assert property (colorBarOn |-> masterTiming && !syncPinsOe)
        else $error("colour bars without master timing or with sync pins driven");
    vbi_blank_a: assert property (blankInputEnable [*2] |-> !vbiDataPass)
        else $error("VBI passed while blank input enabled");
    sleep_pins_a: assert property ($past(resetn) && !powerUpSleepHandover
        && !$past(powerUpSleepHandover) |-> sleepActive == $past(subcarrierResetPin && standardSelectPin))
        else $error("pin sleep wrong");
    phase_reset_a: assert property (subcarrierPhaseReset
        |-> $past(subcarrierResetPin) && !$past(subcarrierResetPin, 2) && !rtcLockEnable)
        else $error("phase reset without pin rise");
    phase_pulse_a: assert property (subcarrierPhaseReset |=> !subcarrierPhaseReset)
        else $error("phase reset longer than one cycle");

    cover property (sleepActive && powerUpSleepHandover);
    cover property (subcarrierPhaseReset);
    cover property (colorBarOn && !syncPinsOe);
endmodule

bind vemr_mode_regs vemr_mode_regs_chk #(.REVISION(REVISION)) uChk (.*);
`default_nettype wire

// File: dv/vemr_mode_regs_tb.sv
// Self-checking bench of the encoder mode registers
`timescale 1ns/1ps
`default_nettype none
module vemr_mode_regs_tb;
    localparam logic [1:0] REV = 2'h2; // Arbitrary value
    // ==========
    // Signals
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        powerUpSleepHandover = 1'b0;
    logic        standardSelectPin = 1'b0;
    logic        subcarrierResetPin = 1'b0;
    logic [1:0]  standardFilterStd = 2'h0;
    logic        timingMasterSel = 1'b0;
    logic        blankInputEnable = 1'b0;
    logic        teletextDataIn = 1'b0;
    logic        teletextBitRequest = 1'b0;
    logic [7:0]  regAddr, regWrData, regRdData, d;
    logic        regWrite, regRead, regAddrHit, regRdValid, teletextRequestOut, pal;
    logic [5:0]  dacPowerDownBits, dacLowPower;
    logic [17:0] dacSource;
    logic        yuvSelect, isNtsc, pedestalOn, squarePixelOn, pixelBlank, masterTiming, sleepActive;
    logic        vbiDataPass, teletextInsert, teletextData, subcarrierPhaseReset, rtcLockEnable;
    logic        chromaOn, burstOn, colorBarOn, syncPinsOe, ySmpteLevel;
    logic [2:0]  vsyncHalfLines;
    logic [9:0]  activePixels;
    logic [10:0] uvLevelMv;
    logic [31:0] seed = 32'hc024;
    logic [3:0]  sideLast = 4'h0;
    logic [7:0]  expQ[$];
    int          n_fail = 0;
    int          samples_checked = 0;
    int          nPulse = 0;

    vemr_mode_regs #(.REVISION(REV)) DUT (.*);
    vemr_host host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));

    initial forever #25 clock = ~clock;

    // ==========
    // Random side inputs, read monitor, pulse count
    always @(posedge clock)
    begin
        seed <= xs(seed);
        sideLast <= {timingMasterSel, blankInputEnable, teletextDataIn, teletextBitRequest};
        {timingMasterSel, blankInputEnable, teletextDataIn, teletextBitRequest} <= seed[3:0];
    end

    always @(posedge clock)
        if (regRdValid === 1'b1)
            check(regRdData, (expQ.size() > 0) ? expQ.pop_front() : 32'h100);

    always @(posedge clock)
        if (subcarrierPhaseReset === 1'b1)
            nPulse <= nPulse + 1;

    // ==========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [17:0] route(input logic [2:0] m);
        if (m[1])
            return {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
        return m[2] ? {3'h2, 3'h1, 3'h3, 3'h5, 3'h4, 3'h0} : {3'h2, 3'h1, 3'h0, 3'h5, 3'h4, 3'h3};
    endfunction

    function automatic logic [7:0] back(input logic [7:0] a, input logic [7:0] v);
        return (a == 8'h03) ? {v[7:2], REV} : v & ((a == 8'h01) ? 8'h7f : (a == 8'h02) ? 8'hef : 8'hff);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] v);
        host.wr(a, v);
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic pins(input logic [5:0] v);
        @(posedge clock);
        {resetn, powerUpSleepHandover, standardSelectPin, subcarrierResetPin, standardFilterStd} <= v;
    endtask

    // ==========
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        pins(6'h20);
        @(posedge clock);
        #1;
        check({pixelBlank, masterTiming, syncPinsOe}, 3'h7);
        check(activePixels, 10'h2d0);
        for (int r = 0; r < 3; r++)
            for (int a = 0; a < 7; a++)
            begin
                d = (r == 0) ? 8'h00 : seed[15:8];
                if (r > 0)
                    host.wr(a[7:0], d);
                if (a > 0 && a < 6)
                    expQ.push_back(back(a[7:0], d));
                host.rd(a[7:0]);
            end
        for (int m = 0; m < 8; m++)
        begin
            put(8'h02, {5'h0, m[2:0]});
            check(dacSource, route(m[2:0]));
            check(yuvSelect, m[0]);
        end
        put(8'h01, 8'h45);
        check(dacPowerDownBits, 6'h05);
        check(dacLowPower, 6'h02);
        for (int j = 0; j < 4; j++)
        begin
            pal = j[0];
            pins({2'h2, j[1] ^ pal, 1'b0, {2{pal ^ ~j[1]}}});
            put(8'h02, j[1] ? 8'h68 : 8'h48);
            put(8'h04, 8'h39);
            for (int k = 0; k < 4; k++)
            begin
                put(8'h05, {5'h0, k[1:0], k[0]});
                check(uvLevelMv, (k == 2) ? 11'h3e8 : (k == 1 || pal) ? 11'h2bc : 11'h3a6);
                check(ySmpteLevel, k[0] ^ pal);
            end
            check({isNtsc, pedestalOn}, {2{~pal}});
            check(activePixels, pal ? 10'h2be : 10'h2c6);
            check(vsyncHalfLines, pal ? 3'h5 : 3'h6);
            check({chromaOn, burstOn, pixelBlank, squarePixelOn, masterTiming}, {4'hc, sideLast[3]});
        end
        put(8'h04, 8'h40);
        check({colorBarOn, syncPinsOe, masterTiming}, 3'h5);
        check({activePixels, vsyncHalfLines}, {10'h2d0, 3'h0});
        put(8'h03, 8'h0c);
        check(teletextRequestOut, 1'b1);
        check({vbiDataPass, teletextData}, {~sideLast[2], sideLast[1]});
        put(8'h03, 8'h18);
        check(teletextRequestOut, teletextBitRequest);
        put(8'h03, 8'h10);
        check({teletextInsert, teletextRequestOut}, 2'h0);
        pins(6'h2c);
        put(8'h04, 8'h00);
        check(sleepActive, 1'b1);
        pins(6'h3c);
        put(8'h02, 8'h00);
        check(sleepActive, 1'b0);
        put(8'h02, 8'h80);
        check(sleepActive, 1'b1);
        pins(6'h00);
        repeat (3) @(posedge clock);
        pins(6'h30);
        repeat (2) @(posedge clock);
        #1;
        check(sleepActive, 1'b0);
        expQ.push_back(8'h00);
        host.rd(8'h02);
        put(8'h04, 8'h02);
        pins(6'h24);
        pins(6'h20);
        put(8'h04, 8'h06);
        check(rtcLockEnable, 1'b1);
        pins(6'h24);
        pins(6'h20);
        put(8'h04, 8'h00);
        pins(6'h24);
        pins(6'h20);
        repeat (3) @(posedge clock);
        check(nPulse, 1);
        check(expQ.size(), 0);
        final_report();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
